// *** include/lpa_pkg.sv ***
// shared constants for the left phase and gain-control configuration registers
`default_nettype none
package lpa_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;
   localparam logic [7:0] PHASE_ADDR = 8'h55;
   localparam logic [7:0] AGC_ADDR = 8'h56;
   localparam logic [7:0] PHASE_RESET = 8'h00;
   localparam logic [7:0] AGC_RESET = 8'h00;
   localparam logic [7:0] PHASE_WRITE_MASK = 8'hff;
   // low nibble of the gain-control register is read-only
   localparam logic [7:0] AGC_WRITE_MASK = 8'hf0;
   localparam int unsigned AGC_EN_BIT = 7;
   localparam int unsigned TARGET_HI = 6;
   localparam int unsigned TARGET_LO = 4;
   localparam int unsigned TARGET_W = 3;
   localparam logic [3:0] RSVD_VALUE = 4'h0;
   localparam int unsigned MAX_SHIFT = 128;
   localparam int unsigned SHIFT_W = 8;
   // target level in tenths of a dB below full scale, indexed by code
   localparam logic [7:0] TARGET_DECI_DB [0:7] = '{8'h37, 8'h50, 8'h64, 8'h78, 8'h8c, 8'haa,
      8'hc8, 8'hf0};
endpackage : lpa_pkg
`default_nettype wire

// *** hw/lpa_reg8.sv ***
// one 8-bit register with a write strobe and a writable-bit mask
`timescale 1ns/1ps
`default_nettype none
module lpa_reg8 #(
   parameter logic [7:0] RESET_VALUE = 8'h00,
   parameter logic [7:0] WRITE_MASK = 8'hff
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic write_strobe,
   input wire logic [7:0] write_data,
   output logic [7:0] value
);
   wire logic [7:0] next_value;
   // read-only bits keep their reset value whatever is written; no strobe holds the old value
   assign next_value = write_strobe ? ((write_data & WRITE_MASK) | (RESET_VALUE & ~WRITE_MASK))
      : value;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         value <= RESET_VALUE;
      end else begin
         value <= next_value;
      end
   end
endmodule : lpa_reg8
`default_nettype wire

// *** hw/lpa_config.sv ***
// left channel phase offset and gain-control enable/target registers
//
// What this block does
// - phase field is signed modulator cycle offset
// - negative codes move left earlier, down -128
// - positive codes delay left, up to 127
// - bit seven enables left gain control
// - three-bit field picks one of eight targets
`timescale 1ns/1ps
`default_nettype none
module lpa_config (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic reg_write,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic left_agc_enable,
   output logic [2:0] left_agc_target,
   output logic [7:0] left_agc_target_deci_db,
   output logic left_delay_left,
   output logic left_delay_right,
   output logic [7:0] left_delay_cycles,
   output logic [7:0] left_phase_offset
);
   ////////////////////////////////////////////////////////////////////////////////
   wire logic hit_phase;
   wire logic hit_agc;
   wire logic [7:0] phase_value;
   wire logic [7:0] agc_value;
   wire logic phase_negative;
   wire logic [7:0] phase_magnitude;
   wire logic [7:0] next_rdata;
   wire logic next_delay_left;
   wire logic next_delay_right;
   wire logic next_agc_enable;
   wire logic [lpa_pkg::TARGET_W-1:0] next_agc_target;
   wire logic [7:0] next_target_deci_db;

   assign hit_phase = reg_write && (reg_addr == lpa_pkg::PHASE_ADDR);
   assign hit_agc = reg_write && (reg_addr == lpa_pkg::AGC_ADDR);

   lpa_reg8 #(
      .RESET_VALUE(lpa_pkg::PHASE_RESET),
      .WRITE_MASK(lpa_pkg::PHASE_WRITE_MASK)
   ) u_phase (
      .clk(clk),
      .reset_n(reset_n),
      .write_strobe(hit_phase),
      .write_data(reg_wdata),
      .value(phase_value)
   );

   lpa_reg8 #(
      .RESET_VALUE(lpa_pkg::AGC_RESET),
      .WRITE_MASK(lpa_pkg::AGC_WRITE_MASK)
   ) u_agc (
      .clk(clk),
      .reset_n(reset_n),
      .write_strobe(hit_agc),
      .write_data(reg_wdata),
      .value(agc_value)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // signed field decode
   assign phase_negative = phase_value[lpa_pkg::SHIFT_W-1];
   assign phase_magnitude = phase_negative ? 8'(~phase_value + 8'h01) : phase_value;

   assign next_rdata = (reg_addr == lpa_pkg::PHASE_ADDR) ? phase_value :
                       (reg_addr == lpa_pkg::AGC_ADDR) ? agc_value : 8'h00;

   // left earlier means the right path is delayed
   assign next_delay_right = phase_negative;
   assign next_delay_left = !phase_negative && (phase_value != 8'h00);
   assign next_agc_enable = agc_value[lpa_pkg::AGC_EN_BIT];
   assign next_agc_target = agc_value[lpa_pkg::TARGET_HI:lpa_pkg::TARGET_LO];
   // level looked up here so the gain loop never decodes the code itself
   assign next_target_deci_db = lpa_pkg::TARGET_DECI_DB[next_agc_target];

   ////////////////////////////////////////////////////////////////////////////////
   // read data registered; one cycle behind the address
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= next_rdata;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         left_phase_offset <= lpa_pkg::PHASE_RESET;
         left_delay_cycles <= 8'h00;
      end else begin
         left_phase_offset <= phase_value;
         left_delay_cycles <= phase_magnitude;
      end
   end

   // direction flags, at most one set
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         left_delay_left <= 1'b0;
         left_delay_right <= 1'b0;
      end else begin
         left_delay_left <= next_delay_left;
         left_delay_right <= next_delay_right;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         left_agc_enable <= 1'b0;
         left_agc_target <= 3'h0;
         left_agc_target_deci_db <= lpa_pkg::TARGET_DECI_DB[0];
      end else begin
         left_agc_enable <= next_agc_enable;
         left_agc_target <= next_agc_target;
         left_agc_target_deci_db <= next_target_deci_db;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // sampled reset_n in the antecedents skips the edge right after an asynchronous clear
   // zero offset means no delay
   a_zero_aligned: assert property (@(posedge clk) disable iff (!reset_n)
      reset_n && $past(phase_value) == 8'h00 |-> !left_delay_left && !left_delay_right
         && left_delay_cycles == 8'h00)
      else $error("zero phase left a delay active");
   a_neg_extreme: assert property (@(posedge clk) disable iff (!reset_n)
      reset_n && $past(phase_value) == 8'h80 |-> left_delay_right && left_delay_cycles == 8'h80)
      else $error("code 0x80 did not give 128 cycles");
   a_neg_one: assert property (@(posedge clk) disable iff (!reset_n)
      reset_n && $past(phase_value) == 8'hff |-> left_delay_right && left_delay_cycles == 8'h01)
      else $error("code 0xff did not give one cycle");
   a_pos_delay: assert property (@(posedge clk) disable iff (!reset_n)
      reset_n && $past(phase_value) inside {[8'h01:8'h7f]}
         |-> left_delay_left && !left_delay_right && left_delay_cycles == $past(phase_value))
      else $error("positive phase not applied to left");
   // written value appears two cycles later
   a_phase_write: assert property (@(posedge clk) disable iff (!reset_n)
      hit_phase |-> ##2 left_phase_offset == $past(reg_wdata, 2))
      else $error("phase write not reflected");
   a_agc_enable: assert property (@(posedge clk) disable iff (!reset_n)
      hit_agc |-> ##2 left_agc_enable == $past(reg_wdata[lpa_pkg::AGC_EN_BIT], 2))
      else $error("gain enable not following write");
   a_agc_target: assert property (@(posedge clk) disable iff (!reset_n)
      hit_agc |-> ##2
         left_agc_target == $past(reg_wdata[lpa_pkg::TARGET_HI:lpa_pkg::TARGET_LO], 2))
      else $error("gain target not following write");
   a_rsvd_zero: assert property (@(posedge clk) disable iff (!reset_n)
      reg_addr == lpa_pkg::AGC_ADDR |=> reg_rdata[3:0] == lpa_pkg::RSVD_VALUE)
      else $error("reserved bits read nonzero");

   ////////////////////////////////////////////////////////////////////////////////
   // steps of a register write followed by a read of the same address
   sequence s_phase_then_read;
      hit_phase ##1 (reg_addr == lpa_pkg::PHASE_ADDR);
   endsequence

   sequence s_agc_then_read;
      hit_agc ##1 (reg_addr == lpa_pkg::AGC_ADDR);
   endsequence

   // reset seen at one edge and released by the next
   sequence s_reset_released;
      !reset_n ##1 reset_n;
   endsequence

   a_phase_readback: assert property (@(posedge clk) disable iff (!reset_n)
      s_phase_then_read |=> reg_rdata == $past(reg_wdata, 2))
      else $error("phase register did not read back");

   // gain register reads back without the reserved nibble
   a_agc_readback: assert property (@(posedge clk) disable iff (!reset_n)
      s_agc_then_read |=> reg_rdata == ($past(reg_wdata, 2) & lpa_pkg::AGC_WRITE_MASK))
      else $error("gain register did not read back");

   // other writes leave the phase field alone
   a_phase_hold: assert property (@(posedge clk) disable iff (!reset_n)
      !hit_phase |=> $stable(phase_value))
      else $error("phase field changed without a write");

   // other writes leave the gain register alone
   a_agc_hold: assert property (@(posedge clk) disable iff (!reset_n)
      !hit_agc |=> $stable(agc_value))
      else $error("gain register changed without a write");

   // no disable here: the check is about the reset itself
   // reset state on first edge after reset
   a_reset_state: assert property (@(posedge clk)
      s_reset_released |-> left_phase_offset == lpa_pkg::PHASE_RESET && !left_delay_left
         && !left_delay_right && left_delay_cycles == 8'h00 && !left_agc_enable
         && left_agc_target == 3'h0 && reg_rdata == 8'h00
         && left_agc_target_deci_db == lpa_pkg::TARGET_DECI_DB[0])
      else $error("outputs not at reset state after reset");

   a_level_table: assert property (@(posedge clk) disable iff (!reset_n)
      left_agc_target_deci_db == lpa_pkg::TARGET_DECI_DB[left_agc_target])
      else $error("target level does not match target code");

   a_delay_exclusive: assert property (@(posedge clk) disable iff (!reset_n)
      !(left_delay_left && left_delay_right))
      else $error("both channel paths delayed at once");

   // left delay within 1 to 127
   a_left_range: assert property (@(posedge clk) disable iff (!reset_n)
      left_delay_left |-> left_delay_cycles inside {[8'h01:8'h7f]})
      else $error("left delay outside its range");

   // right delay within 1 to 128
   a_right_range: assert property (@(posedge clk) disable iff (!reset_n)
      left_delay_right |-> left_delay_cycles inside {[8'h01:8'h80]})
      else $error("right delay outside its range");
endmodule : lpa_config
`default_nettype wire

// *** verif/tb.sv ***
// self-checking bench for the left phase and gain-control registers
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic reg_write = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata, left_agc_target_deci_db, left_delay_cycles, left_phase_offset;
   logic [2:0] left_agc_target;
   logic left_agc_enable, left_delay_left, left_delay_right;
   // xorshift state starts at 34
   logic [31:0] seed = 32'h22;
   logic [7:0] ra;
   logic [7:0] rd;
   int err_count = 0;
   int total_checks = 0;
   int ph = 0;
   int ag = 0;
   int db10 [8] = '{55, 80, 100, 120, 140, 170, 200, 240};
   logic [7:0] edges [8] = '{8'h80, 8'h81, 8'hfe, 8'hff, 8'h00, 8'h01, 8'h7e, 8'h7f};
   always #12.5 clk = ~clk;
   lpa_config uut (.clk, .reset_n, .reg_write, .reg_addr, .reg_wdata, .reg_rdata,
      .left_agc_enable, .left_agc_target, .left_agc_target_deci_db, .left_delay_left,
      .left_delay_right, .left_delay_cycles, .left_phase_offset);
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   // model of both registers compared with every output
   task automatic cmp(input logic [7:0] a);
      int s;
      s = (ph > 127) ? ph - 256 : ph;
      chk("offset", left_phase_offset, 8'(ph));
      chk("rdata", reg_rdata, (a == 8'h55) ? 8'(ph) : (a == 8'h56) ? 8'(ag) : 8'h00);
      chk("later", {7'h0, left_delay_left}, {7'h0, s > 0});
      chk("earlier", {7'h0, left_delay_right}, {7'h0, s < 0});
      chk("cycles", left_delay_cycles, 8'((s < 0) ? -s : s));
      chk("enable", {7'h0, left_agc_enable}, {7'h0, ag[7]});
      chk("target", {5'h0, left_agc_target}, 8'(ag >> 4 & 7));
      chk("level", left_agc_target_deci_db, 8'(db10[ag >> 4 & 7]));
   endtask : cmp
   // called and left at a rising edge; outputs checked two edges after the write edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit last = 1'b1);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      if (a == 8'h55) ph = d;
      if (a == 8'h56) ag = d & 8'hf0;
      if (last) begin
         reg_write <= 1'b0;
         repeat (2) @(posedge clk);
         #1 cmp(a);
         @(posedge clk);
      end
   endtask : wr
   task automatic results();
      if (err_count == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : results
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      #1 cmp(8'h00);
      @(posedge clk);
      foreach (edges[i]) wr(8'h55, edges[i]);
      // reserved nibble of the gain register is always written as zero
      for (int i = 0; i < 8; i++) wr(8'h56, 8'(i << 4) | 8'(xs() & 32'h80));
      wr(8'h55, 8'h80, 1'b0);
      wr(8'h56, 8'hf0);
      for (int i = 0; i < 24; i++) begin
         ra = 8'h54 + 8'(xs() % 4);
         rd = 8'(xs());
         wr(ra, (ra == 8'h56) ? (rd & 8'hf0) : rd);
      end
      // second reset in mid-run must clear both registers
      reset_n <= 1'b0;
      @(posedge clk);
      reset_n <= 1'b1;
      ph = 0;
      ag = 0;
      repeat (2) @(posedge clk);
      #1 cmp(reg_addr);
      results();
   end
   // a hang counts as a mismatch
   initial begin
      #1ms;
      err_count++;
      results();
   end
endmodule : tb
`default_nettype wire
